// File: logic/wdog_top.sv
// watchdog timer with reset-cause flags behind a classic wishbone slave
//
// Chosen here: the Wishbone slave port.
`include "wdog_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module wdog_top #(
  parameter logic [20:0] BASE_CYCLES = `WDOG_BASE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic        dog_osc_i,
  input  wire logic        brownout_i,
  input  wire logic        pin_reset_i,
  input  wire logic        dog_always_on_fuse,
  input  wire logic        dog_restart_i,
  input  wire logic        global_irq_en_i,
  input  wire logic        dog_vector_ack_i,
  output var  logic        dog_irq_req_o,
  output var  logic        sys_reset_pulse_o
);
  localparam wdog_pkg::wdog_state_t RESET_VAL = '{
    cause:   `WDOG_CAUSE_RST,
    fuse_s1: 1'b1,
    fuse_s2: 1'b1,
    default: '0
  };

  wdog_pkg::wdog_state_t q;
  wdog_pkg::wdog_state_t s;

  always_comb begin
    logic                 tick;
    logic                 fuse_prog;
    logic                 re_eff;
    logic                 ie_eff;
    logic                 unlocked;
    logic                 timeout;
    logic                 set_flag;
    logic                 fire;
    logic                 acc_wr;
    logic                 wr_ctrl;
    logic                 wr_cause;
    logic [3:0]           code;
    logic [20:0]          limit;
    logic [7:0]           idx;
    logic [7:0]           wd;
    wdog_pkg::wdog_mode_t mode;
    s         = q;
    tick      = 1'b0;
    fuse_prog = 1'b0;
    re_eff    = 1'b0;
    ie_eff    = 1'b0;
    unlocked  = 1'b0;
    timeout   = 1'b0;
    set_flag  = 1'b0;
    fire      = 1'b0;
    code      = q.period;
    limit     = BASE_CYCLES;
    idx       = wb_adr_i[9:2];
    wd        = wb_dat_i[7:0];
    mode      = wdog_pkg::WDOG_STOP;
    s.sys_rst = 1'b0;

    // two-flop synchronisers, oscillator gets a third flop for edge detect
    s.osc_s1  = dog_osc_i;
    s.osc_s2  = q.osc_s1;
    s.osc_s3  = q.osc_s2;
    s.bo_s1   = brownout_i;
    s.bo_s2   = q.bo_s1;
    s.pin_s1  = pin_reset_i;
    s.pin_s2  = q.pin_s1;
    s.fuse_s1 = dog_always_on_fuse;
    s.fuse_s2 = q.fuse_s1;

    // [R19] [R23] synchronised oscillator edge
    tick      = q.osc_s2 & ~q.osc_s3;
    fuse_prog = ~q.fuse_s2;
    // [R16] reset enable forced by dog flag
    re_eff    = q.reset_en | q.cause[`WDOG_B_DOG] | fuse_prog;
    ie_eff    = q.irq_en & ~fuse_prog;
    unlocked  = (q.unlock_cnt != 3'h0);

    // [R9] [R10] mode selection
    if (fuse_prog) begin
      mode = wdog_pkg::WDOG_RST;
    end else begin
      mode = wdog_pkg::wdog_mode_t'({re_eff, ie_eff});
    end

    // [R17] [R18] period limit, reserved codes clamp
    if (q.period > `WDOG_CODE_MAX) begin
      code = `WDOG_CODE_MAX;
    end
    limit = BASE_CYCLES << code;

    timeout = tick && (mode != wdog_pkg::WDOG_STOP) && (q.cnt >= limit - 21'h000001);

    // [R21] restart and count
    if (dog_restart_i || mode == wdog_pkg::WDOG_STOP) begin
      s.cnt = '0;
    end else if (timeout) begin
      s.cnt = '0;
    end else if (tick) begin
      s.cnt = q.cnt + 21'h000001;
    end

    unique case (mode)
      wdog_pkg::WDOG_STOP: begin
        set_flag = 1'b0;
        fire     = 1'b0;
      end
      // [R6] interrupt mode timeout
      wdog_pkg::WDOG_IRQ: begin
        set_flag = timeout;
        fire     = 1'b0;
      end
      wdog_pkg::WDOG_RST: begin
        set_flag = 1'b0;
        fire     = timeout;
      end
      // [R12] unserviced flag means reset
      wdog_pkg::WDOG_BOTH: begin
        set_flag = timeout & ~q.irq_flag;
        fire     = timeout & q.irq_flag;
      end
    endcase

    // [R22] one-cycle reset pulse
    s.sys_rst = fire;

    // wishbone: ack one cycle after request, write at the sampling edge
    s.ack    = wb_cyc_i & wb_stb_i & ~q.ack;
    acc_wr   = wb_cyc_i & wb_stb_i & q.ack & wb_we_i & wb_sel_i[0];
    wr_ctrl  = acc_wr && (idx == `WDOG_IDX_CTRL);
    wr_cause = acc_wr && (idx == `WDOG_IDX_CAUSE);

    // [R15] unlock countdown
    if (unlocked) begin
      s.unlock_cnt = q.unlock_cnt - 3'h1;
    end

    if (wr_ctrl) begin
      s.irq_en = wd[`WDOG_B_IE];
      // [R14] [R20] protected fields only while unlocked
      if (unlocked && !wd[`WDOG_B_UNLOCK]) begin
        s.reset_en = wd[`WDOG_B_RE] | q.cause[`WDOG_B_DOG];
        s.period   = {wd[`WDOG_B_P3], wd[2:0]};
      end else begin
        s.reset_en = q.reset_en | wd[`WDOG_B_RE];
      end
      // [R15] unlock opens with reset enable written one
      if (wd[`WDOG_B_UNLOCK] && wd[`WDOG_B_RE]) begin
        s.unlock_cnt = `WDOG_UNLOCK_CYC;
      end
      // [R7] written one clears flag
      if (wd[`WDOG_B_FLAG]) begin
        s.irq_flag = 1'b0;
      end
    end

    // [R7] [R11] vector execution clears flag, and enable in combined mode
    if (dog_vector_ack_i && q.irq_flag) begin
      s.irq_flag = 1'b0;
      if (re_eff) begin
        s.irq_en = 1'b0;
      end
    end
    if (set_flag) begin
      s.irq_flag = 1'b1;
    end

    // [R2] [R3] [R4] [R5] cause flags: write zero clears, set wins
    if (wr_cause) begin
      s.cause = q.cause & wd[3:0];
    end
    if (fire) begin
      s.cause[`WDOG_B_DOG] = 1'b1;
    end
    if (q.bo_s2) begin
      s.cause[`WDOG_B_BO] = 1'b1;
    end
    if (q.pin_s2) begin
      s.cause[`WDOG_B_PIN] = 1'b1;
    end

    // [R8] interrupt request gating
    s.irq_req = q.irq_flag & ie_eff & global_irq_en_i;

    // read data captured with ack
    s.rdat = '0;
    if (s.ack && !wb_we_i) begin
      if (idx == `WDOG_IDX_CAUSE) begin
        // [R1] upper cause bits zero
        s.rdat = {4'h0, q.cause};
      end else if (idx == `WDOG_IDX_CTRL) begin
        s.rdat = {q.irq_flag, ie_eff, q.period[3], unlocked, re_eff, q.period[2:0]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= RESET_VAL;
    end else begin
      q <= s;
    end
  end

  assign wb_ack_o          = q.ack;
  assign wb_dat_o          = {24'h000000, q.rdat};
  assign dog_irq_req_o     = q.irq_req;
  assign sys_reset_pulse_o = q.sys_rst;
endmodule
`default_nettype wire

// File: logic/wdog_defs.svh
// constants for the watchdog and reset-cause block
// Functional notes
// [R1] cause bits 7..4 read zero
// [R2] dog reset sets cause bit 3
// [R3] brown-out sets cause bit 2
// [R4] pin reset sets cause bit 1
// [R5] power-on sets bit 0, software clears
// [R6] timeout in irq mode sets irq flag
// [R7] vector or written one clears flag
// [R8] irq needs global and dog enables
// [R9] reset/irq enable pair selects mode
// [R10] programmed fuse forces reset mode
// [R11] combined: vector clears enable and flag
// [R12] combined: unserviced second timeout resets
// [R13] software re-arms irq enable each time
// [R14] protected changes need unlock bit set
// [R15] unlock self-clears four cycles later
// [R16] reset enable forced while dog flag
// [R17] period codes 2048 doubling to 1048576
// [R18] reserved codes act as longest period
// [R19] counter counts slow oscillator ticks
// [R20] software unlocks then writes within four
// [R21] restart instruction zeroes the count
// [R22] reset pulse lasts one clock
// [R23] oscillator synchronised before counting
`ifndef WDOG_DEFS_SVH
`define WDOG_DEFS_SVH
`define WDOG_IDX_CAUSE   8'h35
`define WDOG_IDX_CTRL    8'h60
`define WDOG_B_FLAG      7
`define WDOG_B_IE        6
`define WDOG_B_P3        5
`define WDOG_B_UNLOCK    4
`define WDOG_B_RE        3
`define WDOG_B_DOG       3
`define WDOG_B_BO        2
`define WDOG_B_PIN       1
`define WDOG_B_POR       0
`define WDOG_CAUSE_RST   4'h1
`define WDOG_BASE_CYCLES 21'h000800
`define WDOG_CODE_MAX    4'h9
`define WDOG_UNLOCK_CYC  3'h4
`define WDOG_CLK_HZ      10000000
`endif

// File: logic/wdog_pkg.sv
// types for the watchdog and reset-cause block
package wdog_pkg;
  typedef enum logic [1:0] {
    WDOG_STOP = 2'b00,
    WDOG_IRQ  = 2'b01,
    WDOG_RST  = 2'b10,
    WDOG_BOTH = 2'b11
  } wdog_mode_t;

  typedef struct packed {
    logic        ack;
    logic [7:0]  rdat;
    logic        osc_s1;
    logic        osc_s2;
    logic        osc_s3;
    logic        bo_s1;
    logic        bo_s2;
    logic        pin_s1;
    logic        pin_s2;
    logic        fuse_s1;
    logic        fuse_s2;
    logic [3:0]  cause;
    logic        irq_flag;
    logic        irq_en;
    logic        reset_en;
    logic [3:0]  period;
    logic [2:0]  unlock_cnt;
    logic [20:0] cnt;
    logic        sys_rst;
    logic        irq_req;
  } wdog_state_t;
endpackage

// File: test/wdog_chk.sv
// port assertions for the watchdog block
`timescale 1ns/1ns
`default_nettype none
module wdog_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        dog_osc_i,
  input wire logic        dog_always_on_fuse,
  input wire logic        global_irq_en_i,
  input wire logic        dog_irq_req_o,
  input wire logic        sys_reset_pulse_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [3:0] fz_q;
  wire rd = wb_ack_o && !wb_we_i;
  // fuse held programmed, out of reset, for four edges
  always_ff @(posedge clk) begin
    fz_q <= {fz_q[2:0], !rst && !dog_always_on_fuse};
  end
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not idle");
  a_cause_upper: assert property (rd && wb_adr_i[9:2] == 8'h35 |-> wb_dat_o[31:4] == 28'h0)
    else $error("cause upper bits set");
  a_pulse_single: assert property (sys_reset_pulse_o |=> !sys_reset_pulse_o)
    else $error("reset pulse too long");
  a_irq_gated: assert property (!global_irq_en_i |=> !dog_irq_req_o)
    else $error("irq without global enable");
  a_fuse_mode: assert property (rd && wb_adr_i[9:2] == 8'h60 && &fz_q |-> !wb_dat_o[6] && wb_dat_o[3])
    else $error("fuse does not force reset mode");
  a_pulse_tick: assert property ($stable(dog_osc_i) [*8] |=> !sys_reset_pulse_o)
    else $error("pulse without oscillator tick");
  cover property (sys_reset_pulse_o);
  cover property (dog_irq_req_o);
  cover property (rd && wb_adr_i[9:2] == 8'h60 && wb_dat_o[4]);
endmodule
bind wdog_top wdog_chk wdog_chk_i (.*);
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench for the watchdog block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, osc = 0, bo = 0, pin = 0;
  logic        fuse = 1, rstrt = 0, gie = 0, vack = 0, run = 0, ack, irq, pulse;
  logic [9:0]  adr = 10'h0;
  logic [31:0] dat = 32'h0, dat_o;
  logic [7:0]  r;
  logic [2:0]  ph = 3'h0;
  int          n_fail = 0, comparisons = 0, edges = 0, seed = 32'hB916, n;
  int          q[$];
  always #50 clk = ~clk;
  // slow oscillator, one rising edge every 16 clocks while running
  always @(posedge clk) begin
    if (run) begin
      ph <= ph + 3'h1;
      if (ph == 3'h7) begin
        osc <= ~osc;
        if (!osc) edges <= edges + 1;
      end
    end
  end
  wdog_top #(.BASE_CYCLES(21'h4)) wdog_top_i (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .dog_osc_i(osc), .brownout_i(bo), .pin_reset_i(pin),
    .dog_always_on_fuse(fuse), .dog_restart_i(rstrt), .global_irq_en_i(gie),
    .dog_vector_ack_i(vack), .dog_irq_req_o(irq), .sys_reset_pulse_o(pulse));
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
      n_fail++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {i, 2'b00};
    dat <= {24'h0, d};
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    r = dat_o[7:0];
    cyc <= 0;
    stb <= 0;
    if (n >= 20) begin
      $display("[FAIL] %0t ack %h exp %h", $time, ack, 1'b1);
      n_fail++;
    end
  endtask
  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    bus(0, i, 8'h0);
    chk(r, e);
  endtask
  task automatic wt(input int p);
    n = 0;
    while (!(p ? pulse : irq) && n < 40000) begin @(posedge clk); n++; end
    run <= 0;
    chk(p ? pulse : irq, 1);
  endtask
  task automatic meas(input logic [3:0] c);
    bus(1, 8'h60, 8'h18);
    bus(1, 8'h60, {2'b00, c[3], 2'b00, c[2:0]});
    bus(1, 8'h60, 8'h40);
    @(posedge clk);
    rstrt <= 1;
    edges <= 0;
    run <= 1;
    @(posedge clk);
    rstrt <= 0;
    wt(0);
    chk(edges, c > 9 ? 4 << 9 : 4 << c);
    rdc(8'h60, {2'b11, c[3], 2'b00, c[2:0]});
    bus(1, 8'h60, 8'h80);
    repeat (2) @(posedge clk);
    chk(irq, 0);
  endtask
  initial begin
    #8_000_000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    rdc(8'h35, 8'h01);
    rdc(8'h60, 8'h00);
    rdc(8'h10, 8'h00);
    bus(1, 8'h35, 8'h00);
    pin <= 1;
    bo <= 1;
    repeat (4) @(posedge clk);
    pin <= 0;
    bo <= 0;
    rdc(8'h35, 8'h06);
    bus(1, 8'h35, 8'h04);
    rdc(8'h35, 8'h04);
    gie <= 1;
    q = '{$random(seed) & 3, 10};
    foreach (q[k]) meas(q[k][3:0]);
    bus(1, 8'h60, 8'h18);
    bus(1, 8'h60, 8'h08);
    bus(1, 8'h60, 8'h48);
    run <= 1;
    wt(1);
    rdc(8'h35, 8'h0C);
    @(posedge clk);
    vack <= 1;
    @(posedge clk);
    vack <= 0;
    rdc(8'h60, 8'h08);
    bus(1, 8'h60, 8'h18);
    bus(1, 8'h60, 8'h00);
    rdc(8'h60, 8'h08);
    bus(1, 8'h35, 8'h00);
    bus(1, 8'h60, 8'h18);
    repeat (6) @(posedge clk);
    rdc(8'h60, 8'h08);
    bus(1, 8'h60, 8'h00);
    rdc(8'h60, 8'h08);
    bus(1, 8'h60, 8'h18);
    bus(1, 8'h60, 8'h00);
    rdc(8'h60, 8'h00);
    fuse <= 0;
    bus(1, 8'h60, 8'h40);
    repeat (4) @(posedge clk);
    rdc(8'h60, 8'h08);
    report_and_stop;
  end
endmodule
`default_nettype wire
